// file: irq_ctrl_pkg.sv
// constants, register map and types for the vectored interrupt controller
// assumes: one 200 MHz clock, AXI4-Lite register access, 32 interrupt lines
package irq_ctrl_pkg;

  // ----------------------------------------------------------------
  // line and vector numbering
  // ----------------------------------------------------------------
  localparam int LINE_COUNT = 32;
  localparam logic [5:0] VECTOR_OFFSET = 6'h10;
  localparam logic [5:0] VECTOR_LAST = 6'h2f;
  localparam logic [4:0] LINE_OSC_TRIM = 5'h15;
  localparam logic [4:0] LINE_TIMER_ZERO = 5'h16;
  localparam logic [4:0] LINE_TIMER_ONE = 5'h17;
  localparam logic [4:0] LINE_COMPARATOR = 5'h1a;
  localparam logic [4:0] LINE_PD_WAKE = 5'h1c;
  localparam logic [4:0] LINE_CONV_ZERO = 5'h1d;
  localparam logic [4:0] LINE_CONV_ONE = 5'h1e;
  localparam logic [4:0] LINE_CONV_WINDOW = 5'h1f;
  localparam int GENERIC_LINES = 18;
  localparam logic [31:0] RESERVED_MASK = 32'h0b1c0000;
  localparam logic [31:0] LINE_MASK = ~RESERVED_MASK;

  // ----------------------------------------------------------------
  // vector table
  // ----------------------------------------------------------------
  localparam logic [31:0] TABLE_BASE = 32'h00000000;
  localparam logic [31:0] SP_WORD_OFFSET = 32'h00000000;

  // ----------------------------------------------------------------
  // register map, byte offsets inside the block
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_ENABLE_SET = 12'h000;
  localparam logic [11:0] OFS_ENABLE_CLEAR = 12'h080;
  localparam logic [11:0] OFS_PENDING_SET = 12'h200;
  localparam logic [11:0] OFS_PENDING_CLEAR = 12'h280;
  localparam logic [11:0] OFS_ACTIVE = 12'h300;
  localparam logic [31:0] RESET_ENABLE = 32'h00000000;
  localparam logic [31:0] RESET_PENDING = 32'h00000000;
  localparam logic [31:0] RESET_ACTIVE = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    SEL_ENABLE_SET = 6'h01,
    SEL_ENABLE_CLEAR = 6'h02,
    SEL_PENDING_SET = 6'h04,
    SEL_PENDING_CLEAR = 6'h08,
    SEL_ACTIVE = 6'h10,
    SEL_NONE = 6'h20
  } reg_sel_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_OFFER = 3'h2,
    ST_ACTIVE = 3'h4
  } core_state_type;

endpackage

// file: irq_pick_if.sv
// carrier between the controller and its line picker
// assumes: the picker is purely combinational
`timescale 1ns/1ps
interface irq_pick_if #(parameter int N = 32);
  logic [N-1:0] eligible;
  logic found;
  logic [4:0] line;
  modport ctrl (output eligible, input found, line);
  modport pick (input eligible, output found, line);
endinterface

// file: irq_pick.sv
// lowest-numbered eligible line picker
// assumes: eligible lines already gated by enable and pending
`timescale 1ns/1ps
module irq_pick #(
  parameter int N = 32
) (
  // picker carrier
  irq_pick_if.pick pif
);
  import irq_ctrl_pkg::*;

  if (N < 1 || N > 32) begin : gen_n_check
    $error("irq_pick: N must be 1 to 32");
  end

  // ----------------------------------------------------------------
  // priority search
  // ----------------------------------------------------------------
  always_comb begin
    pif.found = 1'b0;
    pif.line = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (pif.eligible[i]) begin
        pif.found = 1'b1;
        pif.line = 5'(i);
      end
    end
  end

endmodule

// file: irq_ctrl_top.sv
// vectored interrupt controller: enables, pending, active, core offer
// assumes: AXI4-Lite master on SYS_CLK, core acknowledges offers by pulses
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module irq_ctrl_top #(
  parameter int N = irq_ctrl_pkg::LINE_COUNT
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // axi4-lite write address and data
  input wire logic [irq_ctrl_pkg::ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // axi4-lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [irq_ctrl_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // peripheral interrupt sources
  input wire logic [irq_ctrl_pkg::GENERIC_LINES-1:0] GENERIC_IRQ,
  input wire logic OSC_TRIM_IRQ,
  input wire logic TIMER_ZERO_IRQ,
  input wire logic TIMER_ONE_IRQ,
  input wire logic COMPARATOR_IRQ,
  input wire logic POWERDOWN_WAKE_IRQ,
  input wire logic CONVERTER_ZERO_IRQ,
  input wire logic CONVERTER_ONE_IRQ,
  input wire logic CONVERTER_WINDOW_IRQ,
  // processor core
  output logic IRQ_OFFER,
  output logic [5:0] IRQ_VECTOR,
  output logic [31:0] HANDLER_ADDR,
  input wire logic IRQ_ACCEPT,
  input wire logic EXC_RETURN
);
  import irq_ctrl_pkg::*;
  if (N != LINE_COUNT) begin : gen_n_check
    $error("irq_ctrl_top: only 32 lines are supported");
  end
  function automatic reg_sel_type decode(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_ENABLE_SET: decode = SEL_ENABLE_SET;
      OFS_ENABLE_CLEAR: decode = SEL_ENABLE_CLEAR;
      OFS_PENDING_SET: decode = SEL_PENDING_SET;
      OFS_PENDING_CLEAR: decode = SEL_PENDING_CLEAR;
      OFS_ACTIVE: decode = SEL_ACTIVE;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // line gathering and edge detect
  // ----------------------------------------------------------------
  logic [31:0] lines_in;
  logic [31:0] lines_prev_r;
  logic [31:0] hw_set;
  always_comb begin
    lines_in = 32'h00000000;
    lines_in[GENERIC_LINES-1:0] = GENERIC_IRQ;
    lines_in[LINE_OSC_TRIM] = OSC_TRIM_IRQ;
    lines_in[LINE_TIMER_ZERO] = TIMER_ZERO_IRQ;
    lines_in[LINE_TIMER_ONE] = TIMER_ONE_IRQ;
    lines_in[LINE_COMPARATOR] = COMPARATOR_IRQ;
    lines_in[LINE_PD_WAKE] = POWERDOWN_WAKE_IRQ;
    lines_in[LINE_CONV_ZERO] = CONVERTER_ZERO_IRQ;
    lines_in[LINE_CONV_ONE] = CONVERTER_ONE_IRQ;
    lines_in[LINE_CONV_WINDOW] = CONVERTER_WINDOW_IRQ;
  end
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      lines_prev_r <= 32'h00000000;
    end else begin
      lines_prev_r <= lines_in;
    end
  end
  assign hw_set = lines_in & ~lines_prev_r & LINE_MASK;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic aw_full_r, w_full_r, wr_do;
  logic aw_full_nxt, w_full_nxt, bvalid_nxt;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] wbits;
  reg_sel_type wsel;
  assign wr_do = aw_full_r & w_full_r & ~BVALID;
  assign aw_full_nxt = (aw_full_r & ~wr_do) | (AWVALID & AWREADY);
  assign w_full_nxt = (w_full_r & ~wr_do) | (WVALID & WREADY);
  assign bvalid_nxt = wr_do | (BVALID & ~BREADY);
  assign wsel = decode(waddr_r);
  always_comb begin
    wbits = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      wbits[b*8 +: 8] = wstrb_r[b] ? wdata_r[b*8 +: 8] : 8'h00;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
      waddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      AWREADY <= ~aw_full_nxt & ~bvalid_nxt;
      WREADY <= ~w_full_nxt & ~bvalid_nxt;
      BVALID <= bvalid_nxt;
      if (AWVALID && AWREADY) begin
        waddr_r <= AWADDR;
      end
      if (WVALID && WREADY) begin
        wdata_r <= WDATA;
        wstrb_r <= WSTRB;
      end
      if (wr_do) begin
        BRESP <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // ----------------------------------------------------------------
  // enable, pending and active state
  // ----------------------------------------------------------------
  logic [31:0] enable_r, pending_r, active_r;
  logic [31:0] pending_nxt, accept_bit, sw_pend_set, sw_pend_clr;
  core_state_type state_r;
  logic [4:0] offer_line_r;
  logic accept_ok;
  assign sw_pend_set = (wr_do && wsel == SEL_PENDING_SET) ? (wbits & LINE_MASK) : 32'h00000000;
  assign sw_pend_clr = (wr_do && wsel == SEL_PENDING_CLEAR) ? wbits : 32'h00000000;
  // accept only if the line is still enabled and pending
  assign accept_ok = (state_r == ST_OFFER) & IRQ_ACCEPT & enable_r[offer_line_r]
    & pending_r[offer_line_r];
  assign accept_bit = accept_ok ? (32'h00000001 << offer_line_r) : 32'h00000000;
  assign pending_nxt = ((pending_r & ~(sw_pend_clr | accept_bit)) | hw_set | sw_pend_set)
    & LINE_MASK;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      enable_r <= RESET_ENABLE;
    end else if (wr_do && wsel == SEL_ENABLE_SET) begin
      enable_r <= (enable_r | wbits) & LINE_MASK;
    end else if (wr_do && wsel == SEL_ENABLE_CLEAR) begin
      enable_r <= enable_r & ~wbits;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pending_r <= RESET_PENDING;
    end else begin
      pending_r <= pending_nxt;
    end
  end
  // active kept until return or reset
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      active_r <= RESET_ACTIVE;
    end else if (state_r == ST_ACTIVE && EXC_RETURN) begin
      active_r <= 32'h00000000;
    end else begin
      active_r <= active_r | accept_bit;
    end
  end

  // ----------------------------------------------------------------
  // line picker and core offer
  // ----------------------------------------------------------------
  irq_pick_if #(.N(N)) pif ();
  assign pif.eligible = pending_r & enable_r;
  irq_pick #(.N(N)) irq_pick_i (
    .pif(pif)
  );
  chk_pick_found: assert property (@(posedge SYS_CLK) disable iff (RST)
    (|pif.eligible) == pif.found) else $error("picker found flag wrong");
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_r <= ST_IDLE;
      offer_line_r <= 5'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (pif.found) begin
            state_r <= ST_OFFER;
            offer_line_r <= pif.line;
          end
        end
        ST_OFFER: begin
          if (accept_ok) begin
            state_r <= ST_ACTIVE;
          end else if (!(enable_r[offer_line_r] && pending_r[offer_line_r])) begin
            state_r <= ST_IDLE;
          end
        end
        ST_ACTIVE: begin
          if (EXC_RETURN) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // handler address ready with the offer
  // reset points at stack pointer word
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      IRQ_OFFER <= 1'b0;
      IRQ_VECTOR <= 6'h00;
      HANDLER_ADDR <= TABLE_BASE + SP_WORD_OFFSET;
    end else begin
      IRQ_OFFER <= (state_r == ST_IDLE) ? pif.found
        : (state_r == ST_OFFER) && !accept_ok && enable_r[offer_line_r]
          && pending_r[offer_line_r];
      if (state_r == ST_IDLE && pif.found) begin
        IRQ_VECTOR <= {1'b0, pif.line} + VECTOR_OFFSET;
        HANDLER_ADDR <= TABLE_BASE + {24'h000000, ({1'b0, pif.line} + VECTOR_OFFSET), 2'b00};
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  reg_sel_type rsel;
  logic rvalid_nxt;
  assign rsel = decode(ARADDR);
  assign rvalid_nxt = (ARVALID & ARREADY) | (RVALID & ~RREADY);
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= RESP_OKAY;
    end else begin
      ARREADY <= ~rvalid_nxt;
      RVALID <= rvalid_nxt;
      if (ARVALID && ARREADY) begin
        RRESP <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        case (rsel)
          SEL_ENABLE_SET, SEL_ENABLE_CLEAR: RDATA <= enable_r;
          SEL_PENDING_SET, SEL_PENDING_CLEAR: RDATA <= pending_r;
          SEL_ACTIVE: RDATA <= active_r;
          default: RDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_vector_range: assert property (@(posedge SYS_CLK) disable iff (RST)
    IRQ_OFFER |-> (IRQ_VECTOR >= VECTOR_OFFSET && IRQ_VECTOR <= VECTOR_LAST))
    else $error("offered vector outside range");
  chk_reserved_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
    (pending_r & RESERVED_MASK) == 32'h00000000)
    else $error("reserved line pending");
  chk_handler_addr: assert property (@(posedge SYS_CLK) disable iff (RST)
    IRQ_OFFER |-> HANDLER_ADDR == {24'h000000, IRQ_VECTOR, 2'b00})
    else $error("handler address not vector times four");
  chk_enable_set: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_do && wsel == SEL_ENABLE_SET) |=> ((enable_r & $past(wbits) & LINE_MASK)
      == ($past(wbits) & LINE_MASK)))
    else $error("enable set lost");
  chk_disabled_pend: assert property (@(posedge SYS_CLK) disable iff (RST)
    (hw_set[LINE_TIMER_ZERO] && !enable_r[LINE_TIMER_ZERO])
      |=> pending_r[LINE_TIMER_ZERO] && !$rose(active_r[LINE_TIMER_ZERO]))
    else $error("disabled line not pending or activated");
  chk_active_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
    (|active_r && !EXC_RETURN) |=> active_r == $past(active_r))
    else $error("active state lost without return");
  chk_no_disabled_act: assert property (@(posedge SYS_CLK) disable iff (RST)
    $rose(|active_r) |-> $past(enable_r[offer_line_r]))
    else $error("disabled line activated");
  chk_pend_set: assert property (@(posedge SYS_CLK) disable iff (RST)
    (|sw_pend_set) |=> ((pending_r & $past(sw_pend_set)) == $past(sw_pend_set)))
    else $error("software pend set lost");
  chk_accept_clears: assert property (@(posedge SYS_CLK) disable iff (RST)
    (accept_ok && !hw_set[offer_line_r] && !sw_pend_set[offer_line_r])
      |=> !pending_r[$past(offer_line_r)] ##1 !IRQ_OFFER)
    else $error("accept did not clear pending");

endmodule

// file: core_model.sv
// processor core stand-in: takes offers, records vector and handler, returns later
// assumes: offer level and accept/return pulses as the controller hands them over
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controller side
  input wire logic offer,
  input wire logic [5:0] vector,
  input wire logic [31:0] handler,
  output logic accept,
  output logic exc_return,
  // bench side
  input wire logic [3:0] delay,
  input wire logic stall,
  output logic [5:0] last_vector,
  output logic [31:0] last_handler,
  output logic [31:0] entries
);
  logic [3:0] wait_r;
  logic busy_r;
  always_ff @(posedge clk) begin
    accept <= 1'b0;
    exc_return <= 1'b0;
    if (rst) begin
      wait_r <= 4'h0;
      busy_r <= 1'b0;
      last_vector <= 6'h00;
      last_handler <= 32'h00000000;
      entries <= 32'h00000000;
    end else if (!busy_r) begin
      if (offer && wait_r == delay) begin
        accept <= 1'b1;
        busy_r <= 1'b1;
        wait_r <= 4'h0;
        last_vector <= vector;
        last_handler <= handler;
        entries <= entries + 32'h1;
      end else if (offer) begin
        wait_r <= wait_r + 4'h1;
      end else begin
        wait_r <= 4'h0;
      end
    end else if (!stall) begin
      if (wait_r == 4'h4) begin
        exc_return <= 1'b1;
        busy_r <= 1'b0;
        wait_r <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule

// file: nested_vectored_irq_ctrl_test.sv
// self-checking bench for the vectored interrupt controller
// assumes: core_model on the core side, bench as AXI4-Lite master and line driver
`timescale 1ns/1ps
module nested_vectored_irq_ctrl_test;
  import irq_ctrl_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
  logic AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0, BREADY = 1'b1, RREADY = 1'b1;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [3:0] WSTRB = 4'hf;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ_OFFER, IRQ_ACCEPT, EXC_RETURN;
  logic [1:0] BRESP, RRESP, r;
  logic [5:0] IRQ_VECTOR, last_vector;
  logic [31:0] HANDLER_ADDR, last_handler, entries, lines = 32'h0, d;
  logic [3:0] delay = 4'h0;
  logic stall = 1'b0;
  int bad_count = 0;
  int checks = 0;
  always #2.5 SYS_CLK = ~SYS_CLK;
  irq_ctrl_top #(.N(32)) irq_ctrl_top_i (.SYS_CLK(SYS_CLK), .RST(RST), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .GENERIC_IRQ(lines[17:0]), .OSC_TRIM_IRQ(lines[21]),
    .TIMER_ZERO_IRQ(lines[22]), .TIMER_ONE_IRQ(lines[23]), .COMPARATOR_IRQ(lines[26]),
    .POWERDOWN_WAKE_IRQ(lines[28]), .CONVERTER_ZERO_IRQ(lines[29]),
    .CONVERTER_ONE_IRQ(lines[30]), .CONVERTER_WINDOW_IRQ(lines[31]), .IRQ_OFFER(IRQ_OFFER),
    .IRQ_VECTOR(IRQ_VECTOR), .HANDLER_ADDR(HANDLER_ADDR), .IRQ_ACCEPT(IRQ_ACCEPT),
    .EXC_RETURN(EXC_RETURN));
  core_model core_model_i (.clk(SYS_CLK), .rst(RST), .offer(IRQ_OFFER), .vector(IRQ_VECTOR),
    .handler(HANDLER_ADDR), .accept(IRQ_ACCEPT), .exc_return(EXC_RETURN), .delay(delay),
    .stall(stall), .last_vector(last_vector), .last_handler(last_handler), .entries(entries));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (bad_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bound(input int n);
    if (n >= 100) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dat, input logic [3:0] s);
    int n;
    n = 0;
    AWADDR <= a;
    WDATA <= dat;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      n++;
    end while (BVALID !== 1'b1 && n < 100);
    bound(n);
    r = BRESP;
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      n++;
    end while (RVALID !== 1'b1 && n < 100);
    bound(n);
    d = RDATA;
    r = RRESP;
  endtask
  task automatic pulse(input int k);
    lines[k] <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    lines[k] <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic wait_entry(input logic [31:0] target);
    int n;
    n = 0;
    while (entries !== target && n < 100) begin
      @(posedge SYS_CLK);
      n++;
    end
    bound(n);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reset_values();
    logic [11:0] ofs [5] = '{OFS_ENABLE_SET, OFS_ENABLE_CLEAR, OFS_PENDING_SET,
      OFS_PENDING_CLEAR, OFS_ACTIVE};
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i]);
      check(d, 32'h00000000);
    end
    wr(12'h004, 32'h1, 4'hf);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(12'h004);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(OFS_ACTIVE, 32'hffffffff, 4'hf);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    rd(OFS_ACTIVE);
    check(d, 32'h00000000);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic enables();
    wr(OFS_ENABLE_SET, 32'hffffffff, 4'hf);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    wr(OFS_ENABLE_CLEAR, 32'h00000000, 4'hf);
    rd(OFS_ENABLE_SET);
    check(d, LINE_MASK);
    wr(OFS_ENABLE_CLEAR, 32'h00400001, 4'hf);
    rd(OFS_ENABLE_CLEAR);
    check(d, LINE_MASK & 32'hffbffffe);
    wr(OFS_ENABLE_CLEAR, 32'hffffffff, 4'hf);
    rd(OFS_ENABLE_SET);
    check(d, 32'h00000000);
  endtask
  task automatic pending_regs();
    pulse(22);
    repeat (6) @(posedge SYS_CLK);
    check({31'h0, IRQ_OFFER}, 32'h0);
    wr(OFS_PENDING_SET, 32'h00000101, 4'h1);
    wr(OFS_PENDING_SET, 32'h00000000, 4'hf);
    wr(OFS_PENDING_SET, RESERVED_MASK, 4'hf);
    rd(OFS_PENDING_SET);
    check(d, 32'h00400001);
    wr(OFS_PENDING_CLEAR, 32'h00400000, 4'hf);
    rd(OFS_PENDING_CLEAR);
    check(d, 32'h00000001);
    wr(OFS_PENDING_CLEAR, 32'hffffffff, 4'hf);
    check(entries, 32'h0);
  endtask
  task automatic line_walk();
    logic [4:0] tbl [10] = '{LINE_OSC_TRIM, LINE_TIMER_ZERO, LINE_TIMER_ONE, LINE_COMPARATOR,
      LINE_PD_WAKE, LINE_CONV_ZERO, LINE_CONV_ONE, LINE_CONV_WINDOW, 5'h00, 5'h11};
    logic [5:0] v;
    logic [31:0] e;
    for (int i = 0; i < 10; i++) begin
      v = {1'b0, tbl[i]} + VECTOR_OFFSET;
      e = entries + 32'h1;
      delay <= 4'(i % 4);
      wr(OFS_ENABLE_SET, 32'h1 << tbl[i], 4'hf);
      pulse(int'(tbl[i]));
      wait_entry(e);
      check({26'h0, last_vector}, {26'h0, v});
      check(last_handler, TABLE_BASE + {24'h0, v, 2'b00});
      repeat (10) @(posedge SYS_CLK);
      check(entries, e);
      rd(OFS_PENDING_SET);
      check(d, 32'h0);
      wr(OFS_ENABLE_CLEAR, 32'hffffffff, 4'hf);
    end
    delay <= 4'h0;
  endtask
  task automatic active_disabled();
    logic [31:0] e;
    e = entries + 32'h1;
    stall <= 1'b1;
    wr(OFS_ENABLE_SET, 32'h00400000, 4'hf);
    pulse(22);
    wait_entry(e);
    wr(OFS_ENABLE_CLEAR, 32'h00400000, 4'hf);
    rd(OFS_ACTIVE);
    check(d, 32'h00400000);
    pulse(22);
    stall <= 1'b0;
    repeat (12) @(posedge SYS_CLK);
    rd(OFS_ACTIVE);
    check(d, 32'h0);
    rd(OFS_PENDING_SET);
    check(d, 32'h00400000);
    check(entries, e);
    check({31'h0, IRQ_OFFER}, 32'h0);
  endtask
  task automatic offer_withdraw();
    logic [31:0] e;
    e = entries;
    delay <= 4'hf;
    wr(OFS_ENABLE_SET, 32'h00400000, 4'hf);
    pulse(22);
    check({31'h0, IRQ_OFFER}, 32'h1);
    wr(OFS_ENABLE_CLEAR, 32'h00400000, 4'hf);
    repeat (4) @(posedge SYS_CLK);
    check({31'h0, IRQ_OFFER}, 32'h0);
    check(entries, e);
    rd(OFS_PENDING_SET);
    check(d, 32'h00400000);
    wr(OFS_PENDING_CLEAR, 32'h00400000, 4'hf);
    delay <= 4'h0;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge SYS_CLK);
    check(HANDLER_ADDR, TABLE_BASE + SP_WORD_OFFSET);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    reset_values();
    enables();
    pending_regs();
    line_walk();
    offer_withdraw();
    active_disabled();
    final_report();
  end
endmodule
